/* File: src/pwm_ctrl_pkg.sv */
// Shared constants, field layouts and carrier types for the PWM channel control block.
package pwm_ctrl_pkg;
  localparam int NUM_CH = 4;
  localparam int DW = 16;

  // Channel base addresses, index 3 first.
  localparam logic [NUM_CH-1:0][31:0] CH_BASE = {32'h00150000, 32'h00170000,
                                                 32'h001a0000, 32'h001d0000};
  localparam logic [7:0] CTRL0_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'hf0;
  localparam logic [31:0] CTRL0_RESET = 32'h00000022;
  localparam logic [31:0] CTRL0_WMASK = 32'hff9edfff;

  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_RESONANT = 4'h1;
  localparam logic [3:0] MODE_MULTI = 4'h2;
  localparam logic [3:0] MODE_TRIANGULAR = 4'h3;
  localparam logic [3:0] MODE_LEADING = 4'h4;

  localparam logic [3:0] MUX_PASS = 4'h0;
  localparam logic [3:0] MUX_EDGE = 4'h1;
  localparam logic [3:0] MUX_OWN_C = 4'h2;
  localparam logic [3:0] MUX_CROSS = 4'h3;
  localparam logic [3:0] MUX_L3_C = 4'h8;

  localparam logic [1:0] MIN_OFF = 2'h0;
  localparam logic [1:0] MIN_ZERO = 2'h1;
  localparam logic [1:0] MIN_CLAMP = 2'h2;

  localparam int CLK_PERIOD_NS = 5;
  localparam int BLANK_NS = 40;
  localparam logic [7:0] BLANK_CYC = 8'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef struct packed {
    logic [3:0] out_b_source_mux;
    logic [3:0] out_a_source_mux;
    logic cycle_fault_c_en;
    logic [1:0] rsv_22;
    logic cycle_fault_ab_en;
    logic cycle_fault_match_en;
    logic [1:0] min_duty_mode;
    logic rsv_16;
    logic multisync_follower_en;
    logic duty_complement_en;
    logic rsv_13;
    logic resonant_fixed_duty_en;
    logic out_b_disable_level;
    logic out_a_disable_level;
    logic blank_b_en;
    logic blank_a_en;
    logic [3:0] pwm_mode;
    logic out_b_invert;
    logic out_a_invert;
    logic accel_duty_source_sel;
    logic channel_en;
  } ctrl0_s;

  typedef struct packed {
    logic [10:0] rsv;
    logic fault_active;
    logic cycle_fault_hit;
    logic pwm_c;
    logic pwm_b;
    logic pwm_a;
    logic [DW-1:0] count;
  } status_s;

  typedef struct packed {
    logic [DW-1:0] accel_duty;
    logic [DW-1:0] reg_duty;
    logic [DW-1:0] period;
    logic [DW-1:0] filter_duty;
    logic [DW-1:0] auto_high;
    logic [DW-1:0] min_duty_low;
    logic multisync_pulse;
  } chan_in_s;

  typedef struct packed {
    logic pwm_a;
    logic pwm_b;
    logic pwm_c;
    logic blank_a;
    logic blank_b;
  } chan_out_s;
endpackage

/* File: src/pwm_duty_select.sv */
// Duty value conditioning and source selection for one channel.
`timescale 1ns/1ps
module pwm_duty_select import pwm_ctrl_pkg::*; (
  input wire ctrl0_s cfg,
  input wire chan_in_s cin,
  output logic [DW-1:0] duty
);
  logic [DW-1:0] accel;

  always_comb begin
    accel = cin.accel_duty;
    if (cfg.min_duty_mode == MIN_ZERO && accel < cin.min_duty_low) begin
      accel = '0;
    end else if (cfg.min_duty_mode == MIN_CLAMP && accel < cin.min_duty_low) begin
      accel = cin.min_duty_low;
    end
    if (cfg.duty_complement_en) begin
      accel = cin.period - accel;
    end
    if (cfg.pwm_mode == MODE_RESONANT && cfg.accel_duty_source_sel) begin
      duty = cfg.resonant_fixed_duty_en ? cin.auto_high : cin.filter_duty;
    end else if (cfg.accel_duty_source_sel) begin
      duty = accel;
    end else begin
      duty = cin.reg_duty;
    end
  end
endmodule // pwm_duty_select

/* File: src/pwm_out_stage.sv */
// Output source mux, inversion and disable level for one PWM output.
`timescale 1ns/1ps
module pwm_out_stage import pwm_ctrl_pkg::*; (
  input wire logic [8:0] src,
  input wire logic [3:0] sel,
  input wire logic invert,
  input wire logic force_off,
  input wire logic level,
  output logic y
);
  logic pick;

  always_comb begin
    // Codes above the last source fall back to pass-through.
    if (sel <= MUX_L3_C) begin
      pick = src[sel];
    end else begin
      pick = src[MUX_PASS];
    end
    if (force_off) begin
      y = level;
    end else begin
      y = pick ^ invert;
    end
  end
endmodule // pwm_out_stage

/* File: src/pwm_channel_control_zero.sv */
// Four PWM channels with their first control register on an AHB-Lite slave.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module pwm_channel_control_zero import pwm_ctrl_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire chan_in_s [NUM_CH-1:0] chan_in,
  input wire logic [NUM_CH-1:0] fault_trip,
  input wire logic [NUM_CH-1:0] cycle_fault_trip,
  output chan_out_s [NUM_CH-1:0] chan_out
);
  typedef struct packed {
    ctrl0_s [NUM_CH-1:0] ctrl;
    logic [NUM_CH-1:0][DW-1:0] cnt;
    logic [NUM_CH-1:0][7:0] blk_a;
    logic [NUM_CH-1:0][7:0] blk_b;
    logic [NUM_CH-1:0] hit;
    logic [NUM_CH-1:0] fault_s1;
    logic [NUM_CH-1:0] fault_s2;
    logic [NUM_CH-1:0] cyc_s1;
    logic [NUM_CH-1:0] cyc_s2;
    logic [NUM_CH-1:0] a_prev;
    logic [NUM_CH-1:0] b_prev;
    chan_out_s [NUM_CH-1:0] out;
    logic wr_pend;
    logic [1:0] wr_ch;
    logic [31:0] rdata;
  } state_s;

  localparam state_s STATE_RST = '{ctrl: {NUM_CH{CTRL0_RESET}}, default: '0};

  state_s s;
  state_s n;
  logic ap;
  logic dec_ctrl;
  logic dec_stat;
  logic [1:0] dec_ch;
  logic [NUM_CH-1:0][DW-1:0] duty;
  logic [NUM_CH-1:0] ea;
  logic [NUM_CH-1:0] eb;
  logic [NUM_CH-1:0] pa;
  logic [NUM_CH-1:0] pb;
  logic [NUM_CH-1:0] pc;
  logic [NUM_CH-1:0] per_end;
  logic [NUM_CH-1:0] force_off;
  logic [NUM_CH-1:0] ya;
  logic [NUM_CH-1:0] yb;
  logic [NUM_CH-1:0][8:0] src_a;
  logic [NUM_CH-1:0][8:0] src_b;
  status_s [NUM_CH-1:0] stat;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign chan_out = s.out;
  assign ap = hsel && htrans[1] && hready;

  // Only whole-word accesses are expected; hsize is accepted without checking.
  always_comb begin
    dec_ctrl = 1'b0;
    dec_stat = 1'b0;
    dec_ch = 2'd0;
    if (haddr[31:8] == CH_BASE[0][31:8]) begin
      dec_ch = 2'd0;
    end else if (haddr[31:8] == CH_BASE[1][31:8]) begin
      dec_ch = 2'd1;
    end else if (haddr[31:8] == CH_BASE[2][31:8]) begin
      dec_ch = 2'd2;
    end else if (haddr[31:8] == CH_BASE[3][31:8]) begin
      dec_ch = 2'd3;
    end
    if (haddr[31:8] == CH_BASE[dec_ch][31:8]) begin
      if (haddr[7:0] == CTRL0_OFS) begin
        dec_ctrl = 1'b1;
      end else if (haddr[7:0] == STATUS_OFS) begin
        dec_stat = 1'b1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      localparam int B1 = (g + 3) % NUM_CH;
      localparam int B2 = (g + 2) % NUM_CH;
      localparam int B3 = (g + 1) % NUM_CH;

      pwm_duty_select u_duty (
        .cfg(s.ctrl[g]),
        .cin(chan_in[g]),
        .duty(duty[g])
      );

      // Source order follows the mux codes 0 to 8.
      assign src_a[g] = {pc[B3], pc[B2], pc[B1], pb[B1], pa[B1], pb[g], pc[g], ea[g], pa[g]};
      assign src_b[g] = {pc[B3], pc[B2], pc[B1], pb[B1], pa[B1], pa[g], pc[g], eb[g], pb[g]};

      pwm_out_stage u_out_a (
        .src(src_a[g]),
        .sel(s.ctrl[g].out_a_source_mux),
        .invert(s.ctrl[g].out_a_invert),
        .force_off(force_off[g]),
        .level(s.ctrl[g].out_a_disable_level),
        .y(ya[g])
      );

      pwm_out_stage u_out_b (
        .src(src_b[g]),
        .sel(s.ctrl[g].out_b_source_mux),
        .invert(s.ctrl[g].out_b_invert),
        .force_off(force_off[g]),
        .level(s.ctrl[g].out_b_disable_level),
        .y(yb[g])
      );
    end
  endgenerate

  // Edge generation and fault shaping, from registered state and the channel inputs.
  always_comb begin
    logic [DW-1:0] half;
    logic [DW-1:0] dh;
    logic lt;
    logic sh;
    logic cut_a;
    logic cut_b;
    half = '0;
    dh = '0;
    lt = 1'b0;
    sh = 1'b0;
    cut_a = 1'b0;
    cut_b = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      half = chan_in[i].period >> 1;
      dh = duty[i] >> 1;
      lt = s.cnt[i] < duty[i];
      sh = (s.cnt[i] >= half) && (s.cnt[i] - half < duty[i]);
      per_end[i] = (s.cnt[i] >= chan_in[i].period) ||
                   (s.cnt[i] == chan_in[i].period - 16'h0001);
      case (s.ctrl[i].pwm_mode)
        MODE_NORMAL: begin
          ea[i] = lt;
          eb[i] = !lt;
        end
        MODE_RESONANT, MODE_MULTI: begin
          ea[i] = lt;
          eb[i] = sh;
        end
        MODE_TRIANGULAR: begin
          ea[i] = (s.cnt[i] < dh) || (s.cnt[i] >= chan_in[i].period - dh);
          eb[i] = !ea[i];
        end
        MODE_LEADING: begin
          ea[i] = s.cnt[i] >= chan_in[i].period - duty[i];
          eb[i] = !ea[i];
        end
        default: begin
          ea[i] = lt;
          eb[i] = !lt;
        end
      endcase
      // Normal mode gates both the A and B cuts on the match bit; the other modes let A be cut
      // alone and only match B when asked.
      if (s.ctrl[i].pwm_mode == MODE_NORMAL) begin
        cut_a = s.ctrl[i].cycle_fault_match_en;
        cut_b = s.ctrl[i].cycle_fault_match_en;
      end else begin
        cut_a = 1'b1;
        cut_b = s.ctrl[i].cycle_fault_match_en;
      end
      cut_a = cut_a && s.ctrl[i].cycle_fault_ab_en && s.hit[i];
      cut_b = cut_b && s.ctrl[i].cycle_fault_ab_en && s.hit[i];
      pa[i] = ea[i] && !cut_a;
      pb[i] = eb[i] && !cut_b;
      pc[i] = (s.cnt[i] < half) && !(s.ctrl[i].cycle_fault_c_en && s.hit[i]);
      force_off[i] = !s.ctrl[i].channel_en || s.fault_s2[i];
      stat[i] = '{rsv: '0, fault_active: s.fault_s2[i], cycle_fault_hit: s.hit[i],
                  pwm_c: s.out[i].pwm_c, pwm_b: s.out[i].pwm_b,
                  pwm_a: s.out[i].pwm_a, count: s.cnt[i]};
    end
  end

  always_comb begin
    n = s;
    n.rdata = '0;
    n.wr_pend = ap && hwrite && dec_ctrl;
    n.wr_ch = dec_ch;
    if (s.wr_pend) begin
      n.ctrl[s.wr_ch] = ctrl0_s'(hwdata & CTRL0_WMASK);
    end
    // A read right behind a write to the same register sees the new value.
    if (ap && !hwrite) begin
      if (dec_ctrl && s.wr_pend && s.wr_ch == dec_ch) begin
        n.rdata = hwdata & CTRL0_WMASK;
      end else if (dec_ctrl) begin
        n.rdata = s.ctrl[dec_ch];
      end else if (dec_stat) begin
        n.rdata = stat[dec_ch];
      end
    end
    for (int i = 0; i < NUM_CH; i++) begin
      n.fault_s1[i] = fault_trip[i];
      n.fault_s2[i] = s.fault_s1[i];
      n.cyc_s1[i] = cycle_fault_trip[i];
      n.cyc_s2[i] = s.cyc_s1[i];
      if (!s.ctrl[i].channel_en) begin
        n.cnt[i] = '0;
      end else if (s.ctrl[i].multisync_follower_en && chan_in[i].multisync_pulse) begin
        n.cnt[i] = '0;
      end else if (per_end[i]) begin
        n.cnt[i] = '0;
      end else begin
        n.cnt[i] = s.cnt[i] + 16'h0001;
      end
      // A trip in the period's last cycle still counts for the next period.
      n.hit[i] = s.ctrl[i].channel_en && (s.cyc_s2[i] || (s.hit[i] && !per_end[i]));
      n.a_prev[i] = pa[i];
      n.b_prev[i] = pb[i];
      if (pa[i] && !s.a_prev[i]) begin
        n.blk_a[i] = BLANK_CYC;
      end else if (s.blk_a[i] != 8'h00) begin
        n.blk_a[i] = s.blk_a[i] - 8'h01;
      end
      if (pb[i] && !s.b_prev[i]) begin
        n.blk_b[i] = BLANK_CYC;
      end else if (s.blk_b[i] != 8'h00) begin
        n.blk_b[i] = s.blk_b[i] - 8'h01;
      end
      n.out[i].pwm_a = ya[i];
      n.out[i].pwm_b = yb[i];
      n.out[i].pwm_c = pc[i] && !force_off[i];
      n.out[i].blank_a = s.ctrl[i].blank_a_en && n.blk_a[i] != 8'h00;
      n.out[i].blank_b = s.ctrl[i].blank_b_en && n.blk_b[i] != 8'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= STATE_RST;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_disabled_level_a: assert property (
    !s.ctrl[0].channel_en |=> chan_out[0].pwm_a == $past(s.ctrl[0].out_a_disable_level) &&
      !chan_out[0].pwm_c)
    else $error("disabled channel output A not at its disable level");

  a_fault_level_b: assert property (
    $rose(s.fault_s2[0]) |=> chan_out[0].pwm_b == $past(s.ctrl[0].out_b_disable_level))
    else $error("faulted output B not at its disable level");

  a_register_duty: assert property (
    !s.ctrl[0].accel_duty_source_sel |-> duty[0] == chan_in[0].reg_duty)
    else $error("register duty not used with accelerator source off");

  a_complement_duty: assert property (
    s.ctrl[0].accel_duty_source_sel && s.ctrl[0].duty_complement_en &&
    s.ctrl[0].min_duty_mode == MIN_OFF && s.ctrl[0].pwm_mode != MODE_RESONANT
    |-> duty[0] == chan_in[0].period - chan_in[0].accel_duty)
    else $error("complemented duty wrong");

  a_resonant_fixed: assert property (
    s.ctrl[0].accel_duty_source_sel && s.ctrl[0].pwm_mode == MODE_RESONANT &&
    s.ctrl[0].resonant_fixed_duty_en |-> duty[0] == chan_in[0].auto_high)
    else $error("resonant fixed duty not taken from auto-switch-high");

  a_min_duty_zero: assert property (
    s.ctrl[0].accel_duty_source_sel && !s.ctrl[0].duty_complement_en &&
    s.ctrl[0].pwm_mode != MODE_RESONANT && s.ctrl[0].min_duty_mode == MIN_ZERO &&
    chan_in[0].accel_duty < chan_in[0].min_duty_low |-> duty[0] == '0)
    else $error("small duty not suppressed to zero");

  a_invert_pass_a: assert property (
    !force_off[0] && s.ctrl[0].out_a_source_mux == MUX_PASS
    |=> chan_out[0].pwm_a == ($past(pa[0]) ^ $past(s.ctrl[0].out_a_invert)))
    else $error("output A inversion wrong");

  a_cross_mux_b: assert property (
    !force_off[0] && s.ctrl[0].out_b_source_mux == MUX_CROSS &&
    !s.ctrl[0].out_b_invert |=> chan_out[0].pwm_b == $past(pa[0]))
    else $error("output B crossover not taken from A");

  a_follower_restart: assert property (
    s.ctrl[0].channel_en && s.ctrl[0].multisync_follower_en && chan_in[0].multisync_pulse
    |=> s.cnt[0] == '0)
    else $error("follower counter did not restart on sync");

  a_cycle_fault_c: assert property (
    s.ctrl[0].cycle_fault_c_en && s.hit[0] |=> !chan_out[0].pwm_c)
    else $error("output C not cut by cycle fault");

  a_ab_unaffected: assert property (
    !s.ctrl[0].cycle_fault_ab_en |-> pa[0] == ea[0] && pb[0] == eb[0])
    else $error("outputs A and B altered with fault response off");

  a_blank_off: assert property (
    !s.ctrl[0].blank_a_en |=> !chan_out[0].blank_a)
    else $error("blanking A active while disabled");

  a_reserved_zero: assert property (
    (s.ctrl[0] & ~CTRL0_WMASK) == '0 ##1 (s.ctrl[0] & ~CTRL0_WMASK) == '0)
    else $error("reserved control bits set");

  c_cycle_fault_hit: cover property (s.ctrl[0].channel_en ##1 s.hit[0] [*3]);
  c_fault_shutdown: cover property (s.ctrl[0].channel_en && $rose(s.fault_s2[0]));
  c_status_read: cover property (ap && !hwrite && dec_stat ##1 hrdata != '0);
  c_blank_window: cover property ($rose(chan_out[0].blank_a));
endmodule // pwm_channel_control_zero

/* File: bench/power_stage_model.sv */
// Behavioural power stage with fault comparators that trip when the bench commands it.
`timescale 1ns/1ps
module power_stage_model import pwm_ctrl_pkg::*; (
  input wire logic hclk,
  input wire chan_out_s [NUM_CH-1:0] chan_out,
  input wire logic [NUM_CH-1:0] over_current,
  input wire logic [NUM_CH-1:0] cycle_limit,
  output logic [NUM_CH-1:0] fault_trip,
  output logic [NUM_CH-1:0] cycle_fault_trip,
  output logic [NUM_CH-1:0] gate_a_on
);
  // Comparators switch on the clock so the design's synchronisers see clean steps.
  always @(posedge hclk) begin
    fault_trip <= over_current;
    cycle_fault_trip <= cycle_limit;
  end
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      gate_a_on[i] = chan_out[i].pwm_a;
    end
  end
endmodule // power_stage_model

/* File: bench/testbench.sv */
// Self-checking bench for the PWM channel control block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module testbench import pwm_ctrl_pkg::*; ;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp;
  chan_in_s [NUM_CH-1:0] cin;
  chan_out_s [NUM_CH-1:0] cout;
  logic [NUM_CH-1:0] ftrip, ctrip, over, lim;
  int checks, bad_count;
  int cnt [6];

  pwm_channel_control_zero dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .chan_in(cin),
    .fault_trip(ftrip), .cycle_fault_trip(ctrip), .chan_out(cout));
  power_stage_model stage_u (.hclk(hclk), .chan_out(cout), .over_current(over),
    .cycle_limit(lim), .fault_trip(ftrip), .cycle_fault_trip(ctrip), .gate_a_on());

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wait_ready();
    int t;
    t = 0;
    do begin
      @(posedge hclk);
      t++;
    end while (hreadyout !== 1'b1 && t < 50);
    // A bus that never answers ends the run through the common verdict.
    if (hreadyout !== 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic set_in(input logic [15:0] acc, input logic [15:0] flt,
                        input logic [15:0] aut, input logic [15:0] mn);
    for (int i = 0; i < NUM_CH; i++) begin
      cin[i].accel_duty <= acc;
      cin[i].reg_duty <= 16'h0004;
      cin[i].period <= 16'h000a;
      cin[i].filter_duty <= flt;
      cin[i].auto_high <= aut;
      cin[i].min_duty_low <= mn;
      cin[i].multisync_pulse <= 1'b0;
    end
  endtask

  // Ten cycles span exactly one period, so the counts do not depend on phase or latency.
  task automatic run_case(input logic [31:0] ctrl, input int ea, input int eb, input int ec,
                          input int ba, input int bb);
    ahb(1'b1, CH_BASE[0] + 32'(CTRL0_OFS), ctrl);
    repeat (12) @(posedge hclk);
    cnt = '{default: 0};
    repeat (10) begin
      @(posedge hclk);
      cnt[0] += int'(cout[0].pwm_a === 1'b1);
      cnt[1] += int'(cout[0].pwm_b === 1'b1);
      cnt[2] += int'(cout[0].pwm_c === 1'b1);
      cnt[3] += int'(cout[0].blank_a === 1'b1);
      cnt[4] += int'(cout[0].blank_b === 1'b1);
      cnt[5] += int'($isunknown(cout[0]));
    end
    `CHK("unknown output cycles", 0, cnt[5])
    if (ea >= 0) `CHK("pwm_a high cycles", ea, cnt[0])
    if (eb >= 0) `CHK("pwm_b high cycles", eb, cnt[1])
    if (ec >= 0) `CHK("pwm_c high cycles", ec, cnt[2])
    if (ba >= 0) `CHK("blank_a cycles", ba, cnt[3])
    if (bb >= 0) `CHK("blank_b cycles", bb, cnt[4])
  endtask

  task automatic check_regs();
    `CHK("outputs after reset", 5'h00, cout[0])
    for (int i = 0; i < NUM_CH; i++) begin
      ahb(1'b0, CH_BASE[i] + 32'(CTRL0_OFS), 32'h0);
      `CHK("control reset value", 32'h00000022, rd)
    end
    ahb(1'b1, CH_BASE[0], 32'hffffffff);
    ahb(1'b0, CH_BASE[0], 32'h0);
    `CHK("reserved bits read", 32'hff9edfff, rd)
    ahb(1'b1, CH_BASE[0] + 32'h8, 32'hffffffff);
    ahb(1'b0, CH_BASE[0] + 32'h8, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    `CHK("response", 1'b0, hresp)
    ahb(1'b1, CH_BASE[0], CTRL0_RESET);
  endtask

  task automatic check_disabled();
    run_case(32'h00000c00, 10, 10, 0, -1, -1);
    run_case(32'h00000000, 0, 0, 0, 0, 0);
  endtask

  task automatic check_normal();
    run_case(32'h00000001, 4, 6, 5, 0, 0);
    run_case(32'h0000000d, 6, 4, 5, -1, -1);
    run_case(32'h00000301, 4, 6, 5, 8, 8);
    // A held sync keeps the follower's counter at zero, so A and C stay high.
    cin[0].multisync_pulse <= 1'b1;
    run_case(32'h00008001, 10, 0, 10, -1, -1);
    cin[0].multisync_pulse <= 1'b0;
  endtask

  task automatic check_fault();
    over[0] <= 1'b1;
    run_case(32'h00000401, 10, 0, 0, -1, -1);
    ahb(1'b0, CH_BASE[0] + 32'(STATUS_OFS), 32'h0);
    `CHK("status fault flag", 1'b1, rd[20])
    `CHK("status output A", 1'b1, rd[16])
    over[0] <= 1'b0;
  endtask

  task automatic check_accel();
    set_in(16'h0003, 16'h0006, 16'h0002, 16'h0005);
    run_case(32'h00000003, 3, 7, 5, -1, -1);
    run_case(32'h00004003, 7, 3, -1, -1, -1);
    // Centred pulses come in whole halves, so an odd duty of three gives two cycles.
    run_case(32'h00000033, 2, 8, 5, -1, -1);
    run_case(32'h00000043, 3, 7, 5, -1, -1);
    set_in(16'h0002, 16'h0006, 16'h0002, 16'h0005);
    run_case(32'h00020003, 0, 10, -1, -1, -1);
    run_case(32'h00040003, 5, 5, -1, -1, -1);
    run_case(32'h00000003, 2, 8, -1, -1, -1);
  endtask

  task automatic check_resonant();
    run_case(32'h00000013, 6, -1, 5, -1, -1);
    run_case(32'h00001013, 2, -1, 5, -1, -1);
  endtask

  task automatic check_cycle();
    lim[0] <= 1'b1;
    run_case(32'h00980001, 0, 0, 0, -1, -1);
    run_case(32'h00880001, 4, 6, 0, -1, -1);
    run_case(32'h00100001, 4, 6, 5, -1, -1);
    run_case(32'h00100021, 0, 4, 5, -1, -1);
    run_case(32'h00180021, 0, 0, 5, -1, -1);
    lim[0] <= 1'b0;
  endtask

  task automatic check_mux();
    run_case(32'h23000001, 6, 5, 5, -1, -1);
    // The channel below channel 0 is index 3; it feeds mux codes 4 to 6.
    ahb(1'b1, CH_BASE[3] + 32'(CTRL0_OFS), 32'h00000001);
    run_case(32'h64000001, 4, 5, 5, -1, -1);
  endtask

  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    checks = 0;
    bad_count = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    over = '0;
    lim = '0;
    cin = '0;
    set_in(16'h0003, 16'h0006, 16'h0002, 16'h0005);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    check_regs();
    check_disabled();
    check_normal();
    check_fault();
    check_accel();
    check_resonant();
    check_cycle();
    check_mux();
    tally_and_finish();
  end
endmodule // testbench
